// ===== pkg/dhrc_pkg.sv
// Constants shared by the holding-register command block
package dhrc_pkg;
	// ----------------------------------------------------------------
	// Function codes
	// ----------------------------------------------------------------
	localparam logic [7:0] FC_READ_HOLD = 8'h03;
	localparam logic [7:0] FC_WRITE_ONE = 8'h06;
	localparam logic [7:0] FC_WRITE_MANY = 8'h10;
	// ----------------------------------------------------------------
	// Register offsets (a 32-bit value: lower offset is the high word)
	// ----------------------------------------------------------------
	localparam logic [15:0] OFS_COMMAND = 16'h0FA1;
	localparam logic [15:0] OFS_SPARE = 16'h0FA2;
	localparam logic [15:0] OFS_POSITION = 16'h0FA3;
	localparam logic [15:0] OFS_VELOCITY = 16'h0FA5;
	localparam logic [15:0] OFS_ACCEL = 16'h0FA7;
	localparam logic [15:0] OFS_DECEL = 16'h0FA9;
	localparam logic [15:0] OFS_FORCE = 16'h0FAB;
	localparam logic [15:0] OFS_MOTION = 16'h0FAD;
	localparam logic [15:0] OFS_OUTPUT = 16'h0FAF;
	localparam logic [15:0] OFS_LAST = 16'h0FB0;
	localparam int NUM_WORDS = 16;
	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CMD_CODE_LSB = 0;
	localparam int MOVE_SEL_LSB = 8;
	localparam int DOUT_BITS = 2;
	localparam logic [7:0] MOVE_SEL_MAX = 8'h10;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_DISABLE = 8'h00;
	localparam logic [7:0] CMD_ENABLE = 8'h01;
	localparam logic [7:0] CMD_START = 8'h03;
	localparam logic [7:0] CMD_HOME = 8'h05;
	localparam logic [7:0] CMD_ESTOP_A = 8'h08;
	localparam logic [7:0] CMD_ESTOP_B = 8'h09;
	localparam logic [7:0] CMD_STOP = 8'h11;
	localparam logic [7:0] CMD_HOME_HERE = 8'h15;
	// ----------------------------------------------------------------
	// Motion type codes
	// ----------------------------------------------------------------
	localparam logic [31:0] MT_ABSOLUTE = 32'h0000_0000;
	localparam logic [31:0] MT_INC_POS = 32'h0000_0001;
	localparam logic [31:0] MT_INC_NEG = 32'h0000_0002;
	localparam logic [31:0] MT_HOME = 32'h0000_0005;
	localparam logic [31:0] MT_NONE = 32'h0000_0006;
	localparam logic [31:0] MT_FORCE = 32'h0000_0009;
	localparam logic [31:0] MT_ROT_INC_POS = 32'h0000_000B;
	localparam logic [31:0] MT_ROT_INC_NEG = 32'h0000_000C;
	localparam logic [31:0] MT_ROT_VEL_FWD = 32'h0000_000D;
	localparam logic [31:0] MT_ROT_VEL_REV = 32'h0000_000E;
	localparam logic [31:0] MT_STOP = 32'h0000_0010;
	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DHRC_IDLE = 2'b01,
		DHRC_BURST = 2'b10
	} dhrc_req_state_t;
	typedef enum logic [2:0] {
		DHRC_DISABLED = 3'b001,
		DHRC_ENABLED = 3'b010,
		DHRC_ESTOPPED = 3'b100
	} dhrc_drive_state_t;
endpackage : dhrc_pkg

// ===== hdl/dhrc_cmd_decode.sv
// Command byte decoder and drive enable state
`timescale 1ns/100ps
module dhrc_cmd_decode (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_cmd_strobe,
	input wire logic [15:0] i_cmd_word,
	input wire logic [31:0] i_motion_type,
	output logic o_drive_enable,
	output logic o_fault_clear,
	output logic o_start_move,
	output logic o_home,
	output logic o_estop,
	output logic o_stop,
	output logic o_home_here,
	output logic o_motion_type_valid
);
	dhrc_pkg::dhrc_drive_state_t state, next_state;
	logic [7:0] code;
	logic [7:0] sel;
	logic next_clear, next_start, next_home, next_estop, next_stop;
	logic next_home_here, next_mt_valid, next_enable;

	assign code = i_cmd_word[dhrc_pkg::CMD_CODE_LSB +: 8];
	assign sel = i_cmd_word[dhrc_pkg::MOVE_SEL_LSB +: 8];

	always_comb begin
		next_state = state;
		next_clear = 1'b0;
		next_start = 1'b0;
		next_home = 1'b0;
		next_estop = 1'b0;
		next_stop = 1'b0;
		next_home_here = 1'b0;
		case (i_motion_type)
			dhrc_pkg::MT_ABSOLUTE, dhrc_pkg::MT_INC_POS, dhrc_pkg::MT_INC_NEG,
			dhrc_pkg::MT_HOME, dhrc_pkg::MT_NONE, dhrc_pkg::MT_FORCE,
			dhrc_pkg::MT_ROT_INC_POS, dhrc_pkg::MT_ROT_INC_NEG,
			dhrc_pkg::MT_ROT_VEL_FWD, dhrc_pkg::MT_ROT_VEL_REV,
			dhrc_pkg::MT_STOP: next_mt_valid = 1'b1;
			default: next_mt_valid = 1'b0;
		endcase
		if (i_cmd_strobe) begin
			case (code)
				dhrc_pkg::CMD_DISABLE: begin
					next_clear = 1'b1;
					next_state = dhrc_pkg::DHRC_DISABLED;
				end
				dhrc_pkg::CMD_ENABLE: begin
					next_clear = 1'b1;
					next_state = dhrc_pkg::DHRC_ENABLED;
				end
				// Move 0 runs from its own table, so its type must be legal
				dhrc_pkg::CMD_START: begin
					next_start = (state == dhrc_pkg::DHRC_ENABLED) &&
						(sel != 8'h00 || next_mt_valid);
				end
				dhrc_pkg::CMD_HOME: begin
					next_home = (state == dhrc_pkg::DHRC_ENABLED);
				end
				dhrc_pkg::CMD_ESTOP_A, dhrc_pkg::CMD_ESTOP_B: begin
					next_estop = 1'b1;
					next_state = dhrc_pkg::DHRC_ESTOPPED;
				end
				dhrc_pkg::CMD_STOP: begin
					next_stop = 1'b1;
				end
				dhrc_pkg::CMD_HOME_HERE: begin
					next_home_here = 1'b1;
				end
				// Unknown codes are silently dropped
				default: begin
					next_state = state;
				end
			endcase
		end
		next_enable = (next_state == dhrc_pkg::DHRC_ENABLED);
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state <= dhrc_pkg::DHRC_DISABLED;
			o_drive_enable <= 1'b0;
			o_fault_clear <= 1'b0;
			o_start_move <= 1'b0;
			o_home <= 1'b0;
			o_estop <= 1'b0;
			o_stop <= 1'b0;
			o_home_here <= 1'b0;
			o_motion_type_valid <= 1'b1;
		end else begin
			state <= next_state;
			o_drive_enable <= next_enable;
			o_fault_clear <= next_clear;
			o_start_move <= next_start;
			o_home <= next_home;
			o_estop <= next_estop;
			o_stop <= next_stop;
			o_home_here <= next_home_here;
			o_motion_type_valid <= next_mt_valid;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_estop_drops_enable: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		i_cmd_strobe && (code == dhrc_pkg::CMD_ESTOP_A ||
			code == dhrc_pkg::CMD_ESTOP_B) |=> o_estop && !o_drive_enable)
		else $error("estop did not drop enable");
	a_stop_pulse_once: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		i_cmd_strobe && code == dhrc_pkg::CMD_STOP |=> o_stop)
		else $error("stop pulse missing");
	a_stop_only_on_cmd: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		!(i_cmd_strobe && code == dhrc_pkg::CMD_STOP) |=> !o_stop)
		else $error("stop pulse without command");
	a_start_needs_enable: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		o_start_move |-> $past(o_drive_enable))
		else $error("start while not enabled");
	c_estop_seen: cover property (@(posedge i_core_clk) o_estop);
endmodule : dhrc_cmd_decode

// ===== hdl/dhrc_top.sv
// Holding-register file, request handling and command outputs
`timescale 1ns/100ps
module dhrc_top #(
	parameter int MOVE_SEL_LIMIT = 16
) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_req_valid,
	input wire logic [7:0] i_req_func,
	input wire logic [15:0] i_req_addr,
	input wire logic [15:0] i_req_data,
	input wire logic i_req_last,
	output logic o_rsp_valid,
	output logic [7:0] o_rsp_func,
	output logic [15:0] o_rsp_addr,
	output logic [15:0] o_rsp_data,
	output logic [7:0] o_move_select,
	output logic [31:0] o_position,
	output logic [31:0] o_velocity,
	output logic [31:0] o_accel,
	output logic [31:0] o_decel,
	output logic [31:0] o_force,
	output logic [31:0] o_motion_type,
	output logic [1:0] o_dout,
	output logic o_drive_enable,
	output logic o_fault_clear,
	output logic o_start_move,
	output logic o_home,
	output logic o_estop,
	output logic o_stop,
	output logic o_home_here,
	output logic o_motion_type_valid
);
	localparam int NW = dhrc_pkg::NUM_WORDS;
	localparam int I_CMD = 0;
	localparam int I_SPARE = 1;
	localparam int I_OUT_HI = 14;
	localparam int I_OUT_LO = 15;

	// Limit is compared against one byte of the command word
	if (MOVE_SEL_LIMIT < 0 || MOVE_SEL_LIMIT > 255) begin : g_bad_limit
		$error("MOVE_SEL_LIMIT must fit one byte");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	dhrc_pkg::dhrc_req_state_t state, next_state;
	logic [15:0] word [NW];
	logic [15:0] next_word [NW];
	logic [15:0] shadow [NW];
	logic [15:0] next_shadow [NW];
	logic [NW-1:0] mask, next_mask;
	logic bad, next_bad;
	logic next_rsp_valid;
	logic [7:0] next_rsp_func;
	logic [15:0] next_rsp_addr, next_rsp_data;
	logic cmd_strobe;
	logic [15:0] idx_full;
	logic [3:0] idx;
	logic in_range, value_ok;
	logic [NW-1:0] base_mask;

	assign idx_full = i_req_addr - dhrc_pkg::OFS_COMMAND;
	assign idx = idx_full[3:0];
	assign in_range = (i_req_addr >= dhrc_pkg::OFS_COMMAND) &&
		(i_req_addr <= dhrc_pkg::OFS_LAST);
	// Out-of-range move select refuses the write outright
	assign value_ok = (idx != 4'(I_CMD)) ||
		(i_req_data[dhrc_pkg::MOVE_SEL_LSB +: 8] <= 8'(MOVE_SEL_LIMIT));

	// Reserved and unused bits are never stored, so they read as zero
	function automatic logic [15:0] clean(input logic [3:0] i,
		input logic [15:0] d);
		if (i == 4'(I_SPARE) || i == 4'(I_OUT_HI))
			clean = 16'h0000;
		else if (i == 4'(I_OUT_LO))
			clean = {14'h0000, d[dhrc_pkg::DOUT_BITS-1:0]};
		else
			clean = d;
	endfunction : clean

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_word = word;
		next_shadow = shadow;
		next_mask = mask;
		next_bad = bad;
		next_rsp_valid = 1'b0;
		next_rsp_func = o_rsp_func;
		next_rsp_addr = o_rsp_addr;
		next_rsp_data = o_rsp_data;
		cmd_strobe = 1'b0;
		base_mask = (state == dhrc_pkg::DHRC_IDLE) ? '0 : mask;
		if (i_req_valid) begin
			// Any other code mid-burst abandons the burst
			if (i_req_func != dhrc_pkg::FC_WRITE_MANY) begin
				next_state = dhrc_pkg::DHRC_IDLE;
				next_mask = '0;
				next_bad = 1'b0;
			end
			if (i_req_func == dhrc_pkg::FC_READ_HOLD && in_range) begin
				next_rsp_valid = 1'b1;
				next_rsp_func = i_req_func;
				next_rsp_addr = i_req_addr;
				next_rsp_data = word[idx];
			end else if (i_req_func == dhrc_pkg::FC_WRITE_ONE && in_range &&
					value_ok) begin
				next_word[idx] = clean(idx, i_req_data);
				cmd_strobe = (idx == 4'(I_CMD));
				next_rsp_valid = 1'b1;
				next_rsp_func = i_req_func;
				next_rsp_addr = i_req_addr;
				next_rsp_data = i_req_data;
			end else if (i_req_func == dhrc_pkg::FC_WRITE_MANY) begin
				// Stage the group so pairs land together or not at all
				next_mask = base_mask;
				next_bad = (state == dhrc_pkg::DHRC_IDLE) ? 1'b0 : bad;
				if (in_range && value_ok) begin
					next_shadow[idx] = clean(idx, i_req_data);
					next_mask[idx] = 1'b1;
				end else begin
					next_bad = 1'b1;
				end
				if (i_req_last) begin
					next_state = dhrc_pkg::DHRC_IDLE;
					if (!next_bad) begin
						for (int k = 0; k < NW; k++) begin
							if (next_mask[k])
								next_word[k] = next_shadow[k];
						end
						cmd_strobe = next_mask[I_CMD];
						next_rsp_valid = 1'b1;
						next_rsp_func = i_req_func;
						next_rsp_addr = i_req_addr;
						next_rsp_data = i_req_data;
					end
					next_mask = '0;
					next_bad = 1'b0;
				end else begin
					next_state = dhrc_pkg::DHRC_BURST;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NW; g++) begin : g_word
			always_ff @(posedge i_core_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					word[g] <= dhrc_pkg::WORD_RESET;
					shadow[g] <= dhrc_pkg::WORD_RESET;
				end else begin
					word[g] <= next_word[g];
					shadow[g] <= next_shadow[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state <= dhrc_pkg::DHRC_IDLE;
			mask <= '0;
			bad <= 1'b0;
			o_rsp_valid <= 1'b0;
			o_rsp_func <= 8'h00;
			o_rsp_addr <= 16'h0000;
			o_rsp_data <= 16'h0000;
		end else begin
			state <= next_state;
			mask <= next_mask;
			bad <= next_bad;
			o_rsp_valid <= next_rsp_valid;
			o_rsp_func <= next_rsp_func;
			o_rsp_addr <= next_rsp_addr;
			o_rsp_data <= next_rsp_data;
		end
	end

	// ----------------------------------------------------------------
	// Move 0 table and outputs
	// ----------------------------------------------------------------
	assign o_move_select = word[I_CMD][dhrc_pkg::MOVE_SEL_LSB +: 8];
	assign o_position = {word[2], word[3]};
	assign o_velocity = {word[4], word[5]};
	assign o_accel = {word[6], word[7]};
	assign o_decel = {word[8], word[9]};
	assign o_force = {word[10], word[11]};
	assign o_motion_type = {word[12], word[13]};
	assign o_dout = word[I_OUT_LO][dhrc_pkg::DOUT_BITS-1:0];

	dhrc_cmd_decode u_cmd (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_cmd_strobe(cmd_strobe),
		.i_cmd_word(next_word[I_CMD]),
		.i_motion_type({next_word[12], next_word[13]}),
		.o_drive_enable(o_drive_enable),
		.o_fault_clear(o_fault_clear),
		.o_start_move(o_start_move),
		.o_home(o_home),
		.o_estop(o_estop),
		.o_stop(o_stop),
		.o_home_here(o_home_here),
		.o_motion_type_valid(o_motion_type_valid)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_read_returns_word: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		i_req_valid && i_req_func == dhrc_pkg::FC_READ_HOLD && in_range
		|=> o_rsp_valid && o_rsp_data == $past(word[idx]))
		else $error("read answer wrong");
	a_single_write_echo: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		i_req_valid && i_req_func == dhrc_pkg::FC_WRITE_ONE && in_range &&
		value_ok |=> o_rsp_valid && o_rsp_data == $past(i_req_data))
		else $error("single write not echoed");
	a_spare_reads_zero: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		word[I_SPARE] == 16'h0000)
		else $error("spare word not zero");
	a_dout_two_bits: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		word[I_OUT_HI] == 16'h0000 && word[I_OUT_LO][15:2] == 14'h0000)
		else $error("unused output bits set");
	a_move_sel_range: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		o_move_select <= 8'(MOVE_SEL_LIMIT))
		else $error("move select out of range");
	a_bad_addr_silent: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		i_req_valid && !in_range && i_req_func != dhrc_pkg::FC_WRITE_MANY
		|=> !o_rsp_valid)
		else $error("answered a bad address");
	a_burst_holds_regs: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		i_req_valid && i_req_func == dhrc_pkg::FC_WRITE_MANY && !i_req_last
		|=> $stable(o_position) && $stable(o_motion_type))
		else $error("group write leaked early");
	a_cmd_to_start: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		cmd_strobe && next_word[I_CMD][7:0] == dhrc_pkg::CMD_START &&
		o_drive_enable && next_word[I_CMD][15:8] != 8'h00 |=> o_start_move)
		else $error("start while enabled lost");
	a_enable_clears: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		cmd_strobe && next_word[I_CMD][7:0] == dhrc_pkg::CMD_ENABLE
		|=> o_fault_clear && o_drive_enable)
		else $error("enable did not clear");
	a_home_here_pulse: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		cmd_strobe && next_word[I_CMD][7:0] == dhrc_pkg::CMD_HOME_HERE
		|=> o_home_here)
		else $error("home here not pulsed");

	// ----------------------------------------------------------------
	// Refusals and write-back
	// ----------------------------------------------------------------
	a_group_answer: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		i_req_valid && i_req_func == dhrc_pkg::FC_WRITE_MANY && !i_req_last
		|=> !o_rsp_valid)
		else $error("group answered before its last beat");
	a_write_one_lands: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		i_req_valid && i_req_func == dhrc_pkg::FC_WRITE_ONE &&
		i_req_addr == dhrc_pkg::OFS_POSITION
		|=> o_position[31:16] == $past(i_req_data))
		else $error("single write did not land");
	a_refused_sel_keeps: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		i_req_valid && i_req_func == dhrc_pkg::FC_WRITE_ONE && in_range &&
		idx == 4'(I_CMD) &&
		i_req_data[dhrc_pkg::MOVE_SEL_LSB +: 8] > 8'(MOVE_SEL_LIMIT)
		|=> !o_rsp_valid && $stable(o_move_select))
		else $error("out-of-range select was taken");
	a_unknown_func_silent: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		i_req_valid && i_req_func != dhrc_pkg::FC_READ_HOLD &&
		i_req_func != dhrc_pkg::FC_WRITE_ONE &&
		i_req_func != dhrc_pkg::FC_WRITE_MANY |=> !o_rsp_valid)
		else $error("answered an unknown function");
	a_spare_write_kept: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		i_req_valid && i_req_func == dhrc_pkg::FC_WRITE_ONE &&
		i_req_addr == dhrc_pkg::OFS_SPARE
		|=> o_rsp_valid && $stable(o_position) && $stable(o_move_select))
		else $error("spare write disturbed the table");
	a_dout_write: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		i_req_valid && i_req_func == dhrc_pkg::FC_WRITE_ONE &&
		i_req_addr == dhrc_pkg::OFS_LAST
		|=> {14'h0000, o_dout} == ($past(i_req_data) & 16'h0003))
		else $error("digital outputs not driven");
	c_group_write: cover property (@(posedge i_core_clk)
		o_rsp_valid && o_rsp_func == dhrc_pkg::FC_WRITE_MANY);
	c_read: cover property (@(posedge i_core_clk)
		o_rsp_valid && o_rsp_func == dhrc_pkg::FC_READ_HOLD);
	c_start: cover property (@(posedge i_core_clk) o_start_move);
	c_home_here: cover property (@(posedge i_core_clk) o_home_here);
endmodule : dhrc_top

// ===== verification/dhrc_client.sv
// Modbus client model that issues register requests to the block
`timescale 1ns/100ps
module dhrc_client (
	input wire logic i_core_clk,
	input wire logic i_rsp_valid,
	input wire logic [15:0] i_rsp_data,
	output logic o_req_valid,
	output logic [7:0] o_req_func,
	output logic [15:0] o_req_addr,
	output logic [15:0] o_req_data,
	output logic o_req_last
);
	initial begin
		o_req_valid = 1'b0;
		o_req_func = 8'h00;
		o_req_addr = 16'h0000;
		o_req_data = 16'h0000;
		o_req_last = 1'b0;
	end

	// One beat per cycle, launched at the falling edge
	task automatic beat(input logic [7:0] f, input logic [15:0] a,
		input logic [15:0] d, input logic l);
		@(negedge i_core_clk);
		o_req_valid = 1'b1;
		o_req_func = f;
		o_req_addr = a;
		o_req_data = d;
		o_req_last = l;
	endtask : beat

	// Released lines flip so a stale value cannot pass as a good one
	task automatic release_bus();
		@(negedge i_core_clk);
		o_req_valid = 1'b0;
		o_req_func = ~o_req_func;
		o_req_addr = ~o_req_addr;
		o_req_data = ~o_req_data;
		o_req_last = ~o_req_last;
	endtask : release_bus

	task automatic wait_rsp(output logic got, output logic [15:0] rd);
		got = 1'b0;
		rd = 16'h0000;
		for (int n = 0; n < 4 && !got; n++) begin
			if (i_rsp_valid === 1'b1) begin
				got = 1'b1;
				rd = i_rsp_data;
			end else begin
				@(negedge i_core_clk);
			end
		end
	endtask : wait_rsp

	task automatic xfer(input logic [7:0] f, input logic [15:0] a,
		input logic [15:0] d, output logic got, output logic [15:0] rd);
		beat(f, a, d, 1'b1);
		release_bus();
		wait_rsp(got, rd);
	endtask : xfer
endmodule : dhrc_client

// ===== verification/drive_holding_register_commands_test.sv
// Self-checking bench for the holding-register command block
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
	err_count++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); \
	end end
module drive_holding_register_commands_test;
	logic i_core_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic req_valid, req_last, rsp_valid;
	logic [7:0] req_func, rsp_func, move_sel;
	logic [15:0] req_addr, req_data, rsp_addr, rsp_data;
	logic [31:0] pos, vel, acc, dec, frc, mtype;
	logic [1:0] dout;
	logic en, clr, start, home, estop, stop, here, mt_ok;
	int err_count = 0;
	int comparisons = 0;

	initial forever #12.5 i_core_clk = ~i_core_clk;

	dhrc_top i_dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
		.i_req_valid(req_valid), .i_req_func(req_func),
		.i_req_addr(req_addr), .i_req_data(req_data), .i_req_last(req_last),
		.o_rsp_valid(rsp_valid), .o_rsp_func(rsp_func),
		.o_rsp_addr(rsp_addr), .o_rsp_data(rsp_data),
		.o_move_select(move_sel), .o_position(pos), .o_velocity(vel),
		.o_accel(acc), .o_decel(dec), .o_force(frc), .o_motion_type(mtype),
		.o_dout(dout), .o_drive_enable(en), .o_fault_clear(clr),
		.o_start_move(start), .o_home(home), .o_estop(estop), .o_stop(stop),
		.o_home_here(here), .o_motion_type_valid(mt_ok));

	dhrc_client i_client (.i_core_clk(i_core_clk), .i_rsp_valid(rsp_valid),
		.i_rsp_data(rsp_data), .o_req_valid(req_valid),
		.o_req_func(req_func), .o_req_addr(req_addr),
		.o_req_data(req_data), .o_req_last(req_last));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out

	task automatic rd_exp(input logic [15:0] a, input logic [15:0] e);
		logic got;
		logic [15:0] rd;
		i_client.xfer(dhrc_pkg::FC_READ_HOLD, a, 16'h0000, got, rd);
		`CHK(got, 1'b1)
		`CHK(rd, e)
		if (got !== 1'b1) close_out();
	endtask : rd_exp

	// Answer expectation eg: 0 for a request that must be refused
	task automatic wr(input logic [15:0] a, input logic [15:0] d,
		input logic eg);
		logic got;
		logic [15:0] rd;
		i_client.xfer(dhrc_pkg::FC_WRITE_ONE, a, d, got, rd);
		`CHK(got, eg)
		if (eg && got !== 1'b1) close_out();
	endtask : wr

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		`CHK({en, dout, move_sel}, 11'h000)
		`CHK(mt_ok, 1'b1)
		for (int a = 16'h0FA1; a <= 16'h0FB0; a++) rd_exp(a[15:0], 16'h0000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_table();
		logic [191:0] e;
		e = '0;
		for (int k = 0; k < 12; k++) begin
			wr(16'h0FA3 + k[15:0], 16'hA0F0 + k[15:0], 1'b1);
			e = {e[175:0], 16'hA0F0 + k[15:0]};
		end
		`CHK({pos, vel, acc, dec, frc, mtype}, e)
		for (int k = 0; k < 12; k++) begin
			rd_exp(16'h0FA3 + k[15:0], 16'hA0F0 + k[15:0]);
		end
		$display("test table done");
	endtask : t_table

	task automatic t_group();
		logic got;
		logic [15:0] rd;
		i_client.beat(dhrc_pkg::FC_WRITE_MANY, 16'h0FA3, 16'h1234, 1'b0);
		i_client.beat(dhrc_pkg::FC_WRITE_MANY, 16'h0FA4, 16'h5678, 1'b1);
		i_client.release_bus();
		i_client.wait_rsp(got, rd);
		`CHK({got, rsp_addr}, 17'h10FA4)
		`CHK(pos, 32'h1234_5678)
		if (got !== 1'b1) close_out();
		// A bad beat drops the whole group with no answer
		i_client.beat(dhrc_pkg::FC_WRITE_MANY, 16'h0FA3, 16'hDEAD, 1'b0);
		i_client.beat(dhrc_pkg::FC_WRITE_MANY, 16'h0FB1, 16'hBEEF, 1'b1);
		i_client.release_bus();
		i_client.wait_rsp(got, rd);
		`CHK({got, pos}, 33'h0_1234_5678)
		$display("test group done");
	endtask : t_group

	task automatic t_spare();
		wr(16'h0FA2, 16'hFFFF, 1'b1);
		rd_exp(16'h0FA2, 16'h0000);
		`CHK(pos, 32'h1234_5678)
		wr(16'h0FB0, 16'hFFFF, 1'b1);
		`CHK(dout, 2'b11)
		rd_exp(16'h0FB0, 16'h0003);
		wr(16'h0FB0, 16'h0002, 1'b1);
		`CHK(dout, 2'b10)
		$display("test spare done");
	endtask : t_spare

	task automatic t_types();
		logic [15:0] good[11] = '{16'h0, 16'h1, 16'h2, 16'h5, 16'h6, 16'h9,
			16'hB, 16'hC, 16'hD, 16'hE, 16'h10};
		logic [15:0] bad[7] = '{16'h3, 16'h4, 16'h7, 16'h8, 16'hA, 16'hF,
			16'h11};
		wr(16'h0FAD, 16'h0000, 1'b1);
		foreach (good[i]) begin
			wr(16'h0FAE, good[i], 1'b1);
			`CHK(mt_ok, 1'b1)
		end
		foreach (bad[i]) begin
			wr(16'h0FAE, bad[i], 1'b1);
			`CHK(mt_ok, 1'b0)
		end
		wr(16'h0FAE, 16'h0000, 1'b1);
		$display("test types done");
	endtask : t_types

	// Pulses {clear, start, home, estop, stop, here} and enable level
	task automatic t_cmds();
		logic [7:0] c[10] = '{8'h01, 8'h03, 8'h05, 8'h11, 8'h15, 8'h08,
			8'h01, 8'h09, 8'h03, 8'h00};
		logic [6:0] p[10] = '{7'h41, 7'h21, 7'h11, 7'h05, 7'h03, 7'h08,
			7'h41, 7'h08, 7'h00, 7'h40};
		foreach (c[i]) begin
			wr(16'h0FA1, {8'h00, c[i]}, 1'b1);
			`CHK({clr, start, home, estop, stop, here, en}, p[i])
		end
		$display("test commands done");
	endtask : t_cmds

	task automatic t_select();
		logic got;
		logic [15:0] rd;
		// Select 0 needs a legal type; a nonzero select does not
		wr(16'h0FAE, 16'h0007, 1'b1);
		wr(16'h0FA1, 16'h0001, 1'b1);
		wr(16'h0FA1, 16'h0003, 1'b1);
		`CHK({start, en, mt_ok}, 3'b010)
		wr(16'h0FA1, 16'h0303, 1'b1);
		`CHK({start, en}, 2'b11)
		wr(16'h0FA1, 16'h1000, 1'b1);
		`CHK(move_sel, 8'h10)
		wr(16'h0FA1, 16'h1100, 1'b0);
		`CHK(move_sel, 8'h10)
		rd_exp(16'h0FA1, 16'h1000);
		i_client.xfer(dhrc_pkg::FC_READ_HOLD, 16'h0FA0, 16'h0, got, rd);
		`CHK(got, 1'b0)
		i_client.xfer(dhrc_pkg::FC_READ_HOLD, 16'h0FB1, 16'h0, got, rd);
		`CHK(got, 1'b0)
		i_client.xfer(8'h04, 16'h0FA3, 16'h0, got, rd);
		`CHK(got, 1'b0)
		$display("test select done");
	endtask : t_select

	initial begin
		repeat (5) @(negedge i_core_clk);
		i_nrst = 1'b1;
		t_reset();
		t_table();
		t_group();
		t_spare();
		t_types();
		t_cmds();
		t_select();
		// Reset again mid-run: every word must clear
		i_nrst = 1'b0;
		repeat (2) @(negedge i_core_clk);
		i_nrst = 1'b1;
		t_reset();
		close_out();
	end
endmodule : drive_holding_register_commands_test
